// File: src/ths_readout.sv
/*
  Serial temperature readout: two-wire slave on the SCK clock and a
  conversion timer on MCLK, joined by a toggle request and a ready level.
  Assumes an external pull-up on the data wire and a master that keeps
  the data line stable while SCK is high.
*/
`timescale 1ns/1ps
`include "ths_params.svh"

module ths_readout
  import ths_pkg::*;
#(
  parameter int unsigned CONV14_CYC = `THS_T14_MS * `THS_MCLK_KHZ,
  parameter int unsigned CONV13_CYC = `THS_T13_MS * `THS_MCLK_KHZ,
  parameter int unsigned CONV12_CYC = `THS_T12_MS * `THS_MCLK_KHZ,
  parameter int unsigned CONV11_CYC = `THS_T11_MS * `THS_MCLK_KHZ
) (
  input  wire logic        MCLK,
  input  wire logic        RST,
  input  wire logic        SCK,
  input  wire logic        DATA_IN,
  output logic             DATA_OUT,
  output logic             DATA_OE,
  input  wire logic [13:0] TEMP_CODE,
  output logic             CONV_BUSY
);

  // conversion length in cycles for a resolution
  function automatic logic [`THS_TIMER_W-1:0] conv_limit(input ths_res_t r);
    unique case (r)
      THS_RES14: conv_limit = CONV14_CYC[`THS_TIMER_W-1:0];
      THS_RES13: conv_limit = CONV13_CYC[`THS_TIMER_W-1:0];
      THS_RES12: conv_limit = CONV12_CYC[`THS_TIMER_W-1:0];
      THS_RES11: conv_limit = CONV11_CYC[`THS_TIMER_W-1:0];
    endcase
  endfunction : conv_limit

  // code bits kept for a resolution
  function automatic logic [13:0] res_mask(input ths_res_t r);
    res_mask = 14'h3fff << r;
  endfunction : res_mask

  logic                    start_seen;
  logic                    start_clr;
  logic                    stop_seen;
  logic [7:0]              shreg;
  logic [3:0]              cnt;
  logic [3:0]              next_cnt;
  ths_phase_t              phase;
  logic [15:0]             out_sh;
  logic                    want_cfg;
  logic                    req_tgl;
  ths_req_t                req;
  logic                    rdy_s1;
  logic                    rdy_s2;
  logic                    tgl_s1;
  logic                    tgl_s2;
  logic                    tgl_s3;
  logic                    req_edge;
  ths_res_t                res;
  logic                    busy;
  logic [`THS_TIMER_W-1:0] timer;
  logic                    done;
  logic                    valid;
  ths_sample_t             sample;
  logic [`THS_TIMER_W-1:0] age;
  logic [`THS_TIMER_W-1:0] lim_cur;

  // ---------------- SCK domain ----------------

  // start marker: data falls while SCK is high; reset clears it directly so the
  // first start after reset is seen even before any SCK fall
  always_ff @(negedge DATA_IN or posedge start_clr or posedge RST) begin
    if (RST || start_clr) begin
      start_seen <= 1'b0;
    end else begin
      start_seen <= SCK;
    end
  end

  // marker is cleared after the first SCK fall that consumed it
  always_ff @(negedge SCK or posedge RST) begin
    if (RST) begin
      start_clr <= 1'b0;
    end else begin
      start_clr <= start_seen;
    end
  end

  // stop marker: data rises while SCK is high; any rise at SCK low clears it
  always_ff @(posedge DATA_IN or posedge RST) begin
    if (RST) begin
      stop_seen <= 1'b0;
    end else begin
      stop_seen <= SCK;
    end
  end

  // bits shift in on every rising SCK edge
  always_ff @(posedge SCK) begin
    shreg <= {shreg[6:0], DATA_IN};
  end

  // bit position counted on falling edges, 8 means byte complete
  always_comb begin
    if (start_seen) begin
      next_cnt = 4'h0;
    end else if (cnt == `THS_BITS_PER_BYTE) begin
      next_cnt = 4'h0;
    end else begin
      next_cnt = cnt + 4'h1;
    end
  end

  always_ff @(negedge SCK or posedge RST) begin
    if (RST) begin
      cnt <= 4'h0;
    end else begin
      cnt <= next_cnt;
    end
  end

  // ready level into the SCK domain
  always_ff @(negedge SCK or posedge RST) begin
    if (RST) begin
      rdy_s1 <= 1'b0;
      rdy_s2 <= 1'b0;
    end else begin
      rdy_s1 <= valid;
      rdy_s2 <= rdy_s1;
    end
  end

  // link sequencing, acknowledge and read data, all changed at SCK fall
  always_ff @(negedge SCK or posedge RST) begin
    if (RST) begin
      phase    <= THS_PH_IDLE;
      DATA_OE  <= 1'b0;
      out_sh   <= 16'h0000;
      want_cfg <= 1'b0;
      req_tgl  <= 1'b0;
      req      <= '0;
    end else if (start_seen) begin
      phase    <= THS_PH_ADDR;
      DATA_OE  <= 1'b0;
      want_cfg <= 1'b0;
    end else if (stop_seen) begin
      phase   <= THS_PH_IDLE;
      DATA_OE <= 1'b0;
    end else if (next_cnt == `THS_BITS_PER_BYTE) begin
      unique case (phase)
        THS_PH_ADDR: begin
          if (shreg[7:1] == `THS_DEV_ADDR && (!shreg[0] || rdy_s2)) begin
            DATA_OE <= 1'b1;
            phase   <= shreg[0] ? THS_PH_READ : THS_PH_WRITE;
            out_sh  <= sample;
          end else begin
            phase <= THS_PH_IDLE;
          end
        end
        THS_PH_WRITE: begin
          DATA_OE <= 1'b1;
          if (want_cfg) begin
            req      <= '{is_cfg: 1'b1, arg: shreg};
            req_tgl  <= ~req_tgl;
            want_cfg <= 1'b0;
          end else if (shreg == `THS_CMD_CONV) begin
            req     <= '{is_cfg: 1'b0, arg: shreg};
            req_tgl <= ~req_tgl;
          end else if (shreg == `THS_CMD_SETRES) begin
            want_cfg <= 1'b1;
          end
        end
        THS_PH_READ: DATA_OE <= 1'b0;
        THS_PH_IDLE: DATA_OE <= 1'b0;
      endcase
    end else if (phase == THS_PH_READ && next_cnt == 4'h0 && shreg[0]) begin
      phase   <= THS_PH_IDLE; // master did not acknowledge
      DATA_OE <= 1'b0;
    end else if (phase == THS_PH_READ) begin
      DATA_OE <= ~out_sh[15];
      out_sh  <= {out_sh[14:0], 1'b1};
    end else begin
      DATA_OE <= 1'b0;
    end
  end

  // ---------------- MCLK domain ----------------

  // the pin level itself is always low, the enable does the work
  always_ff @(posedge MCLK) begin
    DATA_OUT <= 1'b0;
  end

  // request toggle into the MCLK domain
  always_ff @(posedge MCLK) begin
    if (RST) begin
      tgl_s1 <= 1'b0;
      tgl_s2 <= 1'b0;
      tgl_s3 <= 1'b0;
    end else begin
      tgl_s1 <= req_tgl;
      tgl_s2 <= tgl_s1;
      tgl_s3 <= tgl_s2;
    end
  end

  assign req_edge = tgl_s2 ^ tgl_s3;
  assign done     = busy && timer == '0;

  // resolution setting
  always_ff @(posedge MCLK) begin
    if (RST) begin
      res <= THS_RES14;
    end else if (req_edge && req.is_cfg) begin
      res <= ths_res_t'(req.arg[1:0]);
    end
  end

  // conversion timer, bounded by the limit of the chosen resolution
  always_ff @(posedge MCLK) begin
    if (RST) begin
      busy  <= 1'b0;
      timer <= '0;
    end else if (req_edge && !req.is_cfg) begin
      busy  <= 1'b1;
      timer <= conv_limit(res) - `THS_TIMER_W'(1);
    end else if (done) begin
      busy <= 1'b0;
    end else if (busy) begin
      timer <= timer - `THS_TIMER_W'(1);
    end
  end

  assign CONV_BUSY = busy;

  // result word and its ready level
  always_ff @(posedge MCLK) begin
    if (RST) begin
      valid  <= 1'b0;
      sample <= '0;
    end else if (req_edge && !req.is_cfg) begin
      valid <= 1'b0;
    end else if (done) begin
      valid  <= 1'b1;
      sample <= '{code: TEMP_CODE & res_mask(res), stat: `THS_STAT_TEMP};
    end
  end

  // helper: cycles spent in the running conversion and its limit
  always_ff @(posedge MCLK) begin
    if (RST) begin
      age     <= '0;
      lim_cur <= '0;
    end else if (req_edge && !req.is_cfg) begin
      age     <= '0;
      lim_cur <= conv_limit(res);
    end else if (busy) begin
      age <= age + `THS_TIMER_W'(1);
    end
  end

  // ---------------- checks ----------------

  property p_conv_bound;
    @(posedge MCLK) disable iff (RST) busy |-> age < lim_cur;
  endproperty
  a_conv_bound: assert property (p_conv_bound)
    else $error("conversion ran past its limit");

  property p_done_ready;
    @(posedge MCLK) disable iff (RST) done |=> valid && !busy;
  endproperty
  a_done_ready: assert property (p_done_ready)
    else $error("finished conversion not marked ready");

  property p_pull_only;
    @(posedge MCLK) disable iff (RST) !DATA_OUT;
  endproperty
  a_pull_only: assert property (p_pull_only)
    else $error("data pin driven high");

  property p_capture;
    @(posedge SCK) disable iff (RST) 1'b1 |=> shreg[0] == $past(DATA_IN);
  endproperty
  a_capture: assert property (p_capture)
    else $error("rising edge sample lost");

  property p_start;
    @(negedge SCK) disable iff (RST) start_seen |=> cnt == 4'h0 && phase == THS_PH_ADDR;
  endproperty
  a_start: assert property (p_start)
    else $error("start did not restart the link");

  sequence s_ack;
    DATA_OE ##1 !DATA_OE;
  endsequence

  property p_addr_ack;
    @(negedge SCK) disable iff (RST)
      (!start_seen && !stop_seen && phase == THS_PH_ADDR && next_cnt == 4'h8
       && shreg == {`THS_DEV_ADDR, 1'b0}) |=> s_ack;
  endproperty
  a_addr_ack: assert property (p_addr_ack)
    else $error("own address write not acknowledged for one bit");

  property p_read_bit;
    @(negedge SCK) disable iff (RST)
      (!start_seen && !stop_seen && phase == THS_PH_READ && cnt < 4'h7)
      |=> DATA_OE == !$past(out_sh[15]);
  endproperty
  a_read_bit: assert property (p_read_bit)
    else $error("read bit not driven after falling edge");

  property p_count_range;
    @(negedge SCK) disable iff (RST) cnt <= `THS_BITS_PER_BYTE;
  endproperty
  a_count_range: assert property (p_count_range)
    else $error("bit counter out of range");

endmodule : ths_readout

// File: inc/ths_params.svh
/*
  Constants of the serial temperature readout: bus address, command codes,
  conversion time limits and widths.
  Assumes inclusion by bare name from the package and the design files.
*/
`ifndef THS_PARAMS_SVH
`define THS_PARAMS_SVH

// bus address and command bytes
`define THS_DEV_ADDR    7'h40
`define THS_CMD_CONV    8'hf3
`define THS_CMD_SETRES  8'he6

// conversion time limits, in ms, per resolution
`define THS_T14_MS      50
`define THS_T13_MS      25
`define THS_T12_MS      13
`define THS_T11_MS      7

// main clock rate in kHz, so cycles = ms * kHz
`define THS_MCLK_KHZ    10000

// widths and field values
`define THS_TIMER_W     20
`define THS_BITS_PER_BYTE 4'h8
`define THS_STAT_TEMP   2'h0

`endif

// File: inc/ths_pkg.sv
/*
  Types of the serial temperature readout: resolution, link request word
  and conversion sample.
  Assumes the constants header in the include path.
*/
`include "ths_params.svh"

package ths_pkg;

  // selectable conversion resolution
  typedef enum logic [1:0] {
    THS_RES14,
    THS_RES13,
    THS_RES12,
    THS_RES11
  } ths_res_t;

  // serial link state
  typedef enum logic [1:0] {
    THS_PH_IDLE,
    THS_PH_ADDR,
    THS_PH_WRITE,
    THS_PH_READ
  } ths_phase_t;

  // request passed from the link to the conversion logic
  typedef struct packed {
    logic       is_cfg;
    logic [7:0] arg;
  } ths_req_t;

  // finished conversion word, msb first on the link
  typedef struct packed {
    logic [13:0] code;
    logic [1:0]  stat;
  } ths_sample_t;

endpackage : ths_pkg

// File: tb/ths_host_model.sv
/*
  Host model: two-wire master that makes SCK and pulls the data wire low
  through host_oe; SCK stands high between frames.
  Assumes the bench resolves the wire from both pull-down enables.
*/
`timescale 1ns/1ps
module ths_host_model (
  output logic      sck,
  output logic      host_oe,
  input  wire logic data_wire
);
  int hp = 6;       // half period of SCK in ns
  int glitches = 0; // wire changes seen while SCK is high

  // idle: clock parked high, wire released to the pull-up
  initial begin
    sck = 1'b1;
    host_oe = 1'b0;
  end

  // one bit: set while SCK low, held over the whole high phase
  task automatic bit_io(input logic b, output logic r);
    logic r2;
    #1 host_oe = !b;
    #(hp - 1) sck = 1'b1;
    #(hp / 2) r = data_wire;
    #(hp - hp / 2) r2 = data_wire;
    if (r2 !== r) glitches++;
    sck = 1'b0;
  endtask : bit_io

  // start or repeated start: wire falls while SCK high
  task automatic start_cond();
    #1 host_oe = 1'b0;
    #(hp - 1) sck = 1'b1;
    #(hp) host_oe = 1'b1;
    #(hp) sck = 1'b0;
  endtask : start_cond

  // stop: wire rises while SCK high, clock then stands high
  task automatic stop_cond();
    #1 host_oe = 1'b1;
    #(hp - 1) sck = 1'b1;
    #(hp) host_oe = 1'b0;
    #(hp);
  endtask : stop_cond

  // byte to the device, msb first, then the device's ack bit
  task automatic byte_w(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    bit_io(1'b1, r);
    ack = !r;
  endtask : byte_w

  // byte from the device; last byte is answered with a release
  task automatic byte_r(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask : byte_r
endmodule : ths_host_model

// File: tb/testbench.sv
/*
  Bench for the serial readout: host model on the wire, short conversion
  limits, checks on acks, conversion length and read data.
  Assumes the readout and host model are compiled before it.
*/
`timescale 1ns/1ps
module testbench;
  localparam int lim [4] = '{40, 30, 20, 10};
  logic        mclk = 1'b0;
  logic        rst = 1'b0;
  logic [13:0] temp_code = 14'h0000;
  logic        sck;
  logic        host_oe;
  logic        dut_oe;
  logic        dut_out;
  logic        busy;
  wire         data_wire = !(dut_oe | host_oe); // pull-up unless pulled low
  int          failures = 0;
  int          n_checks = 0;
  int          cycles = 0;

  ths_readout #(.CONV14_CYC(40), .CONV13_CYC(30), .CONV12_CYC(20), .CONV11_CYC(10)) dut_u (
    .MCLK(mclk), .RST(rst), .SCK(sck), .DATA_IN(data_wire), .DATA_OUT(dut_out),
    .DATA_OE(dut_oe), .TEMP_CODE(temp_code), .CONV_BUSY(busy));
  ths_host_model host_u (.sck(sck), .host_oe(host_oe), .data_wire(data_wire));

  // main clock and hang limit
  always #50 mclk = ~mclk;
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 6000) begin
      failures++;
      end_of_test();
    end
  end

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : end_of_test

  // the device never drives the wire high
  always @(posedge dut_oe) check("pull level", {15'h0, dut_out}, 16'h0000);

  // wrong address, read with no result, repeated start, stray byte
  task automatic t_refused();
    logic a0, a1, a2, a3;
    host_u.start_cond();
    host_u.byte_w(8'h82, a0);
    host_u.start_cond();
    host_u.byte_w(8'h81, a1);
    host_u.start_cond();
    host_u.byte_w(8'h80, a2);
    host_u.byte_w(8'h55, a3);
    host_u.stop_cond();
    check("refused acks", {12'h0, a0, a1, a2, a3}, 16'h0003);
    repeat (4) @(posedge mclk);
    $display("refused done");
  endtask : t_refused

  // set resolution, convert, poll while busy, read the result
  task automatic t_conv(input int r);
    logic a0, a1, a2, a3;
    logic [7:0] d0, d1;
    int n;
    @(posedge mclk) #1 temp_code = 14'h2a5b ^ 14'(r * 'h1111);
    host_u.start_cond();
    host_u.byte_w(8'h80, a0);
    host_u.byte_w(8'he6, a1);
    host_u.byte_w(8'(r), a2);
    host_u.stop_cond();
    check("set acks", {13'h0, a0, a1, a2}, 16'h0007);
    repeat (4) @(posedge mclk);
    host_u.start_cond();
    host_u.byte_w(8'h80, a0);
    host_u.byte_w(8'hf3, a1);
    host_u.stop_cond();
    n = 0;
    while (busy !== 1'b1 && n < 20) begin
      @(posedge mclk) #1 n++;
    end
    check("busy", {15'h0, busy}, 16'h0001);
    n = 0;
    // length of busy counted while a poll runs on the wire
    fork
      while (busy === 1'b1 && n < 100) begin
        @(posedge mclk) #1 n++;
      end
      begin
        host_u.start_cond();
        host_u.byte_w(8'h81, a3);
        host_u.stop_cond();
      end
    join
    check("conv cycles", 16'(n), 16'(lim[r]));
    check("poll ack", {15'h0, a3}, 16'h0000);
    host_u.start_cond();
    host_u.byte_w(8'h81, a0);
    host_u.byte_r(1'b0, d0);
    host_u.byte_r(1'b1, d1);
    host_u.stop_cond();
    check("read ack", {15'h0, a0}, 16'h0001);
    check("result", {d0, d1}, {temp_code & (14'h3fff << r), 2'b00});
    $display("conversion %0d done", r);
  endtask : t_conv

  // slow, stretched clock reads the standing result again
  task automatic t_slow();
    logic a0;
    logic [7:0] d0, d1;
    host_u.hp = 500;
    host_u.start_cond();
    host_u.byte_w(8'h81, a0);
    host_u.byte_r(1'b0, d0);
    host_u.byte_r(1'b1, d1);
    host_u.stop_cond();
    host_u.hp = 6;
    check("slow ack", {15'h0, a0}, 16'h0001);
    check("slow result", {d0, d1}, {temp_code & 14'h3ff8, 2'b00});
    check("stable bits", 16'(host_u.glitches), 16'h0000);
    $display("slow clock done");
  endtask : t_slow

  // reset, then every scenario in turn
  initial begin
    #1 rst = 1'b1; // a real rising edge so the link side clears too
    repeat (10) @(posedge mclk);
    #1 rst = 1'b0;
    @(posedge mclk);
    check("idle outputs", {13'h0, busy, dut_oe, dut_out}, 16'h0000);
    t_refused();
    for (int r = 0; r < 4; r++) t_conv(r);
    t_slow();
    end_of_test();
  end
endmodule : testbench
